//--- core/nvprog_cfg.svh
// Addresses, bit positions, reset values and timing counts for the
// nonvolatile programming control pair. Definitions only.
`ifndef NVPROG_CFG_SVH
`define NVPROG_CFG_SVH

// ----------------------------------------------------------------
// Device register and array map
// ----------------------------------------------------------------
`define EE_CTL_ADDR 16'h101a
`define EPA_CTL_ADDR 16'h101c
`define EPB_CTL_ADDR 16'h101e
`define EE_BASE_DEF 16'h1f00
`define EE_SIZE 256
`define EE_WPR_IDX 8'h00
`define EP_SIZE_DEF 8192
`define EP_A_BASE_DEF 16'h6000
`define EP_B_BASE_DEF 16'h6000

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define EXEC_BIT 0
`define SEL_BIT 1
`define VPP_BIT 6
`define CTL_RESET 8'h00

// ----------------------------------------------------------------
// Controller registers (APB byte addresses) and command fields
// ----------------------------------------------------------------
`define H_CMD 8'h00
`define H_ADDR 8'h04
`define H_WDATA 8'h08
`define H_STAT 8'h0c
`define H_GO_BIT 0
`define H_WE_BIT 1

// ----------------------------------------------------------------
// Timing, clock period 100 ns
// ----------------------------------------------------------------
`define CLK_NS 100
`define VPP_SETUP_NS 2000
`define READ_WAIT_NS 4000
`define VPP_SETUP_CYC ((`VPP_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define READ_WAIT_CYC ((`READ_WAIT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

//--- core/nvprog_dev.sv
// Data EEPROM and program EPROM programming control, device end.
// Assumes one CPU memory cycle at a time on the link, and that the
// mode pin level and protect override come from the pad logic.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "nvprog_cfg.svh"

module nvprog_dev #(
   parameter logic [15:0] EE_BASE = `EE_BASE_DEF,
   parameter int EP_SIZE = `EP_SIZE_DEF,
   parameter logic [15:0] EP_A_BASE = `EP_A_BASE_DEF,
   parameter logic [15:0] EP_B_BASE = `EP_B_BASE_DEF,
   parameter bit EP_TWO = 1'b0
) (
   // Clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Pad conditions
   input wire logic vpp_on_mode_pin_i,
   input wire logic protect_override_mode_i,
   // CPU memory link
   nvprog_if.dev bus,
   // Programming drive to the arrays
   output logic eeprom_pulse_o,
   output logic [1:0] eprom_pulse_o,
   output logic [1:0] prog_voltage_connect_o
);

   localparam int EP_DEPTH = EP_TWO ? 2 * EP_SIZE : EP_SIZE;
   localparam int EPW = $clog2(EP_DEPTH);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] base,
                                     input int size);
      logic [16:0] lo;
      logic [16:0] hi;
      lo = {1'b0, base};
      hi = lo + 17'(size);
      in_range = ({1'b0, a} >= lo) && ({1'b0, a} < hi);
   endfunction

   function automatic nvprog_pkg::region_t decode(input logic [15:0] a);
      nvprog_pkg::region_t r;
      r = nvprog_pkg::RG_NONE;
      if (a == `EE_CTL_ADDR) begin
         r = nvprog_pkg::RG_CTL_EE;
      end else if (a == `EPA_CTL_ADDR) begin
         r = nvprog_pkg::RG_CTL_A;
      end else if (EP_TWO && a == `EPB_CTL_ADDR) begin
         r = nvprog_pkg::RG_CTL_B;
      end else if (in_range(a, EE_BASE, `EE_SIZE)) begin
         r = nvprog_pkg::RG_EE;
      end else if (in_range(a, EP_A_BASE, EP_SIZE)) begin
         r = nvprog_pkg::RG_EPA;
      end else if (EP_TWO && in_range(a, EP_B_BASE, EP_SIZE)) begin
         r = nvprog_pkg::RG_EPB;
      end
      decode = r;
   endfunction

   function automatic logic [EPW-1:0] ep_index(input logic [15:0] a,
                                               input logic second);
      logic [15:0] off;
      off = second ? (a - EP_B_BASE) : (a - EP_A_BASE);
      ep_index = second ? EPW'(EP_SIZE) + EPW'(off) : EPW'(off);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic ee_exe_ff, nxt_ee_exe;
   logic ee_sel_ff, nxt_ee_sel;
   logic [7:0] ee_lat_addr_ff, nxt_ee_lat_addr;
   logic [7:0] ee_lat_data_ff, nxt_ee_lat_data;
   logic [1:0] ep_exe_ff, nxt_ep_exe;
   logic [1:0] ep_vpp_ff, nxt_ep_vpp;
   logic [EPW-1:0] ep_lat_idx_ff, nxt_ep_lat_idx;
   logic [7:0] ep_lat_data_ff, nxt_ep_lat_data;
   logic ep_lat_arr_ff, nxt_ep_lat_arr;
   logic [7:0] rdata_ff, nxt_rdata;
   logic ack_ff, nxt_ack;

   // Cell arrays; EPROM comes up erased, EEPROM unprotected.
   // Cells are never reset, so only the write process may touch them
   logic [7:0] ee_mem [`EE_SIZE] = '{default: 8'h00};
   logic [7:0] ep_mem [EP_DEPTH] = '{default: 8'hff};

   nvprog_pkg::region_t rg;
   logic ep_second;
   logic [7:0] ee_old, ee_wpr, ee_new, ep_old, ep_new;
   logic ee_ok, ee_we, ep_we;

   // ----------------------------------------------------------------
   // Programming cells
   // ----------------------------------------------------------------
   always_comb begin
      ee_old = ee_mem[ee_lat_addr_ff];
      ee_wpr = ee_mem[`EE_WPR_IDX];
      ee_ok = !ee_wpr[ee_lat_addr_ff[7:5]] || protect_override_mode_i;
      ee_we = ee_exe_ff && ee_ok;
      ee_new = ee_sel_ff ? (ee_old | ee_lat_data_ff)
                         : (ee_old & ee_lat_data_ff);
      ep_old = ep_mem[ep_lat_idx_ff];
      // Only a 0 can be burned in; nothing drives a cell back to 1
      ep_new = ep_old & ep_lat_data_ff;
      ep_we = ep_exe_ff[ep_lat_arr_ff] && ep_vpp_ff[ep_lat_arr_ff]
              && vpp_on_mode_pin_i;
   end

   always_ff @(posedge ref_clk_i) begin
      if (ce_i) begin
         if (ee_we) begin
            ee_mem[ee_lat_addr_ff] <= ee_new;
         end
         if (ep_we) begin
            ep_mem[ep_lat_idx_ff] <= ep_new;
         end
      end
   end

   // ----------------------------------------------------------------
   // CPU cycles and control registers
   // ----------------------------------------------------------------
   always_comb begin
      rg = decode(bus.mem_addr);
      ep_second = (rg == nvprog_pkg::RG_EPB);
      nxt_ee_exe = ee_exe_ff;
      nxt_ee_sel = ee_sel_ff;
      nxt_ee_lat_addr = ee_lat_addr_ff;
      nxt_ee_lat_data = ee_lat_data_ff;
      nxt_ep_exe = ep_exe_ff;
      nxt_ep_vpp = ep_vpp_ff;
      nxt_ep_lat_idx = ep_lat_idx_ff;
      nxt_ep_lat_data = ep_lat_data_ff;
      nxt_ep_lat_arr = ep_lat_arr_ff;
      nxt_rdata = rdata_ff;
      nxt_ack = bus.mem_req;
      if (bus.mem_req && bus.mem_we) begin
         unique case (rg)
            nvprog_pkg::RG_CTL_EE: begin
               nxt_ee_exe = bus.mem_wdata[`EXEC_BIT];
               if (!ee_exe_ff) begin
                  nxt_ee_sel = bus.mem_wdata[`SEL_BIT];
               end
            end
            nvprog_pkg::RG_CTL_A, nvprog_pkg::RG_CTL_B: begin
               nxt_ep_exe[ep_second || rg == nvprog_pkg::RG_CTL_B] =
                  bus.mem_wdata[`EXEC_BIT];
               nxt_ep_vpp[ep_second || rg == nvprog_pkg::RG_CTL_B] =
                  bus.mem_wdata[`VPP_BIT];
            end
            nvprog_pkg::RG_EE: begin
               if (!ee_exe_ff) begin
                  nxt_ee_lat_addr = bus.mem_addr[7:0];
                  nxt_ee_lat_data = bus.mem_wdata;
               end
            end
            nvprog_pkg::RG_EPA, nvprog_pkg::RG_EPB: begin
               // Latch only with the pin voltage and the connect bit on, outside execute
               if (vpp_on_mode_pin_i && ep_vpp_ff[ep_second]
                   && !ep_exe_ff[ep_second]) begin
                  nxt_ep_lat_idx = ep_index(bus.mem_addr, ep_second);
                  nxt_ep_lat_data = bus.mem_wdata;
                  nxt_ep_lat_arr = ep_second;
               end
            end
            nvprog_pkg::RG_NONE: begin
            end
         endcase
      end else if (bus.mem_req) begin
         unique case (rg)
            nvprog_pkg::RG_CTL_EE:
               nxt_rdata = {6'h00, ee_sel_ff, ee_exe_ff};
            nvprog_pkg::RG_CTL_A:
               nxt_rdata = {1'b0, ep_vpp_ff[0], 5'h00, ep_exe_ff[0]};
            nvprog_pkg::RG_CTL_B:
               nxt_rdata = {1'b0, ep_vpp_ff[1], 5'h00, ep_exe_ff[1]};
            nvprog_pkg::RG_EE:
               nxt_rdata = ee_exe_ff ? ee_lat_data_ff
                                     : ee_mem[bus.mem_addr[7:0]];
            nvprog_pkg::RG_EPA, nvprog_pkg::RG_EPB:
               nxt_rdata = ep_mem[ep_index(bus.mem_addr, ep_second)];
            nvprog_pkg::RG_NONE:
               nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         ee_exe_ff <= 1'b0;
         ee_sel_ff <= 1'b0;
         ee_lat_addr_ff <= 8'h00;
         ee_lat_data_ff <= 8'h00;
         ep_exe_ff <= 2'h0;
         ep_vpp_ff <= 2'h0;
         ep_lat_idx_ff <= '0;
         ep_lat_data_ff <= 8'hff;
         ep_lat_arr_ff <= 1'b0;
         rdata_ff <= `CTL_RESET;
         ack_ff <= 1'b0;
      end else if (ce_i) begin
         ee_exe_ff <= nxt_ee_exe;
         ee_sel_ff <= nxt_ee_sel;
         ee_lat_addr_ff <= nxt_ee_lat_addr;
         ee_lat_data_ff <= nxt_ee_lat_data;
         ep_exe_ff <= nxt_ep_exe;
         ep_vpp_ff <= nxt_ep_vpp;
         ep_lat_idx_ff <= nxt_ep_lat_idx;
         ep_lat_data_ff <= nxt_ep_lat_data;
         ep_lat_arr_ff <= nxt_ep_lat_arr;
         rdata_ff <= nxt_rdata;
         ack_ff <= nxt_ack;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus.mem_rdata = rdata_ff;
   assign bus.mem_ack = ack_ff;
   assign eeprom_pulse_o = ee_exe_ff;
   assign eprom_pulse_o = ep_exe_ff;
   assign prog_voltage_connect_o = ep_vpp_ff;

endmodule

//--- core/nvprog_host.sv
// Controller end: APB registers turn software orders into single CPU
// memory cycles on the link. Assumes an APB master on ref_clk_i.
`timescale 1ns/1ps
`include "nvprog_cfg.svh"

module nvprog_host (
   // Clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // CPU memory link
   nvprog_if.cpu bus
);

   localparam logic [7:0] GAP_MAX = 8'(`READ_WAIT_CYC);

   nvprog_pkg::host_state_t st_ff, nxt_st;
   logic [15:0] addr_ff, nxt_addr;
   logic [7:0] wdata_ff, nxt_wdata;
   logic we_ff, nxt_we;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [7:0] gap_ff, nxt_gap;
   logic acc, busy, mapped, ep_ctl;

   // ----------------------------------------------------------------
   // Order sequencing
   // ----------------------------------------------------------------
   always_comb begin
      acc = psel_i && penable_i;
      busy = (st_ff != nvprog_pkg::HS_IDLE);
      mapped = (paddr_i == `H_CMD) || (paddr_i == `H_ADDR)
               || (paddr_i == `H_WDATA) || (paddr_i == `H_STAT);
      ep_ctl = we_ff && (addr_ff == `EPA_CTL_ADDR
                         || addr_ff == `EPB_CTL_ADDR);
      nxt_st = st_ff;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_we = we_ff;
      nxt_rdata = rdata_ff;
      nxt_gap = (gap_ff < GAP_MAX) ? gap_ff + 8'h01 : gap_ff;
      // Setup staging is refused while an order is in flight
      if (acc && pwrite_i && !busy) begin
         if (paddr_i == `H_ADDR) begin
            nxt_addr = pwdata_i[15:0];
         end
         if (paddr_i == `H_WDATA) begin
            nxt_wdata = pwdata_i[7:0];
         end
         if (paddr_i == `H_CMD && pwdata_i[`H_GO_BIT]) begin
            nxt_we = pwdata_i[`H_WE_BIT];
            nxt_st = nvprog_pkg::HS_HOLD;
         end
      end
      unique case (st_ff)
         nvprog_pkg::HS_IDLE: begin
         end
         nvprog_pkg::HS_HOLD: begin
            // 4 us after any EPROM control write covers both the
            // voltage settle before execute and the read-back wait
            if (gap_ff >= GAP_MAX) begin
               nxt_st = nvprog_pkg::HS_ISSUE;
            end
         end
         nvprog_pkg::HS_ISSUE: begin
            nxt_st = nvprog_pkg::HS_WAIT;
            if (ep_ctl) begin
               nxt_gap = 8'h00;
            end
         end
         nvprog_pkg::HS_WAIT: begin
            if (bus.mem_ack) begin
               // One cycle at a time keeps the latched byte intact
               nxt_st = nvprog_pkg::HS_IDLE;
               if (!we_ff) begin
                  nxt_rdata = bus.mem_rdata;
               end
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         st_ff <= nvprog_pkg::HS_IDLE;
         addr_ff <= 16'h0000;
         wdata_ff <= 8'h00;
         we_ff <= 1'b0;
         rdata_ff <= 8'h00;
         gap_ff <= GAP_MAX;
      end else if (ce_i) begin
         st_ff <= nxt_st;
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
         we_ff <= nxt_we;
         rdata_ff <= nxt_rdata;
         gap_ff <= nxt_gap;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb begin
      prdata_o = 32'h0000_0000;
      if (paddr_i == `H_ADDR) begin
         prdata_o = {16'h0000, addr_ff};
      end else if (paddr_i == `H_WDATA) begin
         prdata_o = {24'h00_0000, wdata_ff};
      end else if (paddr_i == `H_STAT) begin
         prdata_o = {16'h0000, rdata_ff, 7'h00, busy};
      end
   end

   assign pready_o = 1'b1;
   assign pslverr_o = acc && !mapped;
   assign bus.mem_req = (st_ff == nvprog_pkg::HS_ISSUE);
   assign bus.mem_we = we_ff;
   assign bus.mem_addr = addr_ff;
   assign bus.mem_wdata = wdata_ff;

endmodule

//--- core/nvprog_if.sv
// CPU memory-cycle link between the controller and the device end.
// Assumes both ends share ref_clk_i; the bench joins them.
`timescale 1ns/1ps
interface nvprog_if;
   logic mem_req;
   logic mem_we;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;
   logic mem_ack;

   modport dev (
      input mem_req, mem_we, mem_addr, mem_wdata,
      output mem_rdata, mem_ack
   );

   modport cpu (
      output mem_req, mem_we, mem_addr, mem_wdata,
      input mem_rdata, mem_ack
   );
endinterface

//--- core/nvprog_pkg.sv
// Types shared by the device end and the controller end.
// Assumes nothing beyond a SystemVerilog compiler.
package nvprog_pkg;

   typedef enum logic [2:0] {
      RG_NONE, RG_EE, RG_EPA, RG_EPB, RG_CTL_EE, RG_CTL_A, RG_CTL_B
   } region_t;

   typedef enum logic [1:0] {
      HS_IDLE, HS_HOLD, HS_ISSUE, HS_WAIT
   } host_state_t;

endpackage

//--- verif/nvprog_checker.sv
// Link checker for the controller and device pair.
// Assumes the bench feeds it the link signals and the shared clock.
`timescale 1ns/1ps
`include "nvprog_cfg.svh"

module nvprog_checker #(
   parameter logic [15:0] EE_BASE = `EE_BASE_DEF
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Memory link
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack
);
   // ------------------------------------------------------------
   // Shadow of control bits, rebuilt from link writes only
   // ------------------------------------------------------------
   logic ee_exe_ff, ee_sel_ff, ep_exe_ff, ep_con_ff;
   logic nxt_ee_exe, nxt_ee_sel, nxt_ep_exe, nxt_ep_con;
   logic [7:0] latch_ff, nxt_latch;
   logic [7:0] gap_ff, nxt_gap;
   logic wr, rd, in_ee;

   assign wr = mem_req & mem_we;
   assign rd = mem_req & ~mem_we;
   assign in_ee = (mem_addr[15:8] == EE_BASE[15:8]);

   always_comb begin
      nxt_ee_exe = ee_exe_ff;
      nxt_ee_sel = ee_sel_ff;
      nxt_ep_exe = ep_exe_ff;
      nxt_ep_con = ep_con_ff;
      nxt_latch = latch_ff;
      // Cycles since the last EPROM control write, saturating
      nxt_gap = (gap_ff < 8'(`READ_WAIT_CYC)) ? gap_ff + 8'h01 : gap_ff;
      if (wr && (mem_addr == `EPA_CTL_ADDR
                 || mem_addr == `EPB_CTL_ADDR)) begin
         nxt_gap = 8'h00;
      end
      if (wr && mem_addr == `EE_CTL_ADDR) begin
         nxt_ee_exe = mem_wdata[`EXEC_BIT];
         if (!ee_exe_ff) begin
            nxt_ee_sel = mem_wdata[`SEL_BIT];
         end
      end
      if (wr && mem_addr == `EPA_CTL_ADDR) begin
         nxt_ep_exe = mem_wdata[`EXEC_BIT];
         nxt_ep_con = mem_wdata[`VPP_BIT];
      end
      // A write during execute must not disturb the byte in flight
      if (wr && in_ee && !ee_exe_ff) begin
         nxt_latch = mem_wdata;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         ee_exe_ff <= 1'h0;
         ee_sel_ff <= 1'h0;
         ep_exe_ff <= 1'h0;
         ep_con_ff <= 1'h0;
         latch_ff <= 8'h00;
         gap_ff <= 8'(`READ_WAIT_CYC);
      end else begin
         ee_exe_ff <= nxt_ee_exe;
         ee_sel_ff <= nxt_ee_sel;
         ep_exe_ff <= nxt_ep_exe;
         ep_con_ff <= nxt_ep_con;
         latch_ff <= nxt_latch;
         gap_ff <= nxt_gap;
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   ack_follows_a: assert property (mem_req |=> mem_ack)
      else $error("link request not acknowledged next cycle");
   ack_cause_a: assert property (mem_ack |-> $past(mem_req))
      else $error("acknowledge without a request");
   req_single_a: assert property (mem_req |=> !mem_req)
      else $error("link request longer than one cycle");
   ee_ctl_read_a: assert property (
      rd && mem_addr == `EE_CTL_ADDR |=>
      mem_rdata == {6'h00, ee_sel_ff, ee_exe_ff})
      else $error("eeprom control read differs from shadow");
   ee_latch_read_a: assert property (
      rd && in_ee && ee_exe_ff |=> mem_rdata == latch_ff)
      else $error("read during execute not the latched byte");
   ep_ctl_read_a: assert property (
      rd && mem_addr == `EPA_CTL_ADDR |=>
      mem_rdata == {1'h0, ep_con_ff, 5'h00, ep_exe_ff})
      else $error("eprom control read differs from shadow");
   epb_absent_a: assert property (
      rd && mem_addr == `EPB_CTL_ADDR |=> mem_rdata == 8'h00)
      else $error("second eprom control answers in one-array build");
   rdata_kept_a: assert property (wr |=> $stable(mem_rdata))
      else $error("write cycle disturbed read data");
   ep_gap_a: assert property (
      mem_req |-> gap_ff >= 8'(`READ_WAIT_CYC))
      else $error("link cycle too soon after eprom control write");
endmodule

//--- verif/tb_eeprom_eprom_program_control.sv
// Bench for the controller and device pair joined by the link.
// Assumes the design package, header and interface are compiled first.
`timescale 1ns/1ps
`include "nvprog_cfg.svh"

module tb_eeprom_eprom_program_control;
   logic ref_clk = 1'h0;
   logic rst_b = 1'h0;
   logic ce = 1'h1;
   logic vpp_pin = 1'h0;
   logic override = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, ee_pulse;
   logic [1:0] ep_pulse, vconn;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   nvprog_if link();

   nvprog_dev i_nvprog_dev (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
      .ce_i(ce), .vpp_on_mode_pin_i(vpp_pin),
      .protect_override_mode_i(override), .bus(link),
      .eeprom_pulse_o(ee_pulse), .eprom_pulse_o(ep_pulse),
      .prog_voltage_connect_o(vconn));

   nvprog_host i_nvprog_host (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
      .ce_i(ce), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .bus(link));

   nvprog_checker i_nvprog_checker (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
      .mem_req(link.mem_req), .mem_we(link.mem_we),
      .mem_addr(link.mem_addr), .mem_wdata(link.mem_wdata),
      .mem_rdata(link.mem_rdata), .mem_ack(link.mem_ack));

   always #50 ref_clk = ~ref_clk;

   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task automatic give_verdict();
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge ref_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      @(posedge ref_clk);
      while (pready !== 1'h1) @(posedge ref_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // One link cycle; the global cycle ceiling bounds the busy poll
   task automatic mem_op(input logic we, input logic [15:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      logic [31:0] r;
      logic e;
      apb(1'h1, `H_ADDR, {16'h0000, a}, r, e);
      apb(1'h1, `H_WDATA, {24'h000000, d}, r, e);
      apb(1'h1, `H_CMD, {30'h0, we, 1'h1}, r, e);
      r = 32'h1;
      while (r[0] !== 1'h0) apb(1'h0, `H_STAT, 32'h0, r, e);
      q = r[15:8];
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      mem_op(1'h1, a, d, q);
   endtask

   task automatic rdc(input logic [15:0] a, input logic [7:0] exp,
                      input string what);
      logic [7:0] q;
      mem_op(1'h0, a, 8'h00, q);
      chk(what, {24'h0, exp}, {24'h0, q});
   endtask

   task automatic ee_prog(input logic [15:0] a, input logic [7:0] d);
      wr(a, d);
      wr(`EE_CTL_ADDR, 8'h03);
      wr(`EE_CTL_ADDR, 8'h00);
   endtask

   task automatic ep_prog(input logic [7:0] d);
      wr(16'h6000, d);
      wr(`EPA_CTL_ADDR, 8'h41);
      chk("eprom pulse", 32'h1, {30'h0, ep_pulse});
      wr(`EPA_CTL_ADDR, 8'h40);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rdc(`EE_CTL_ADDR, 8'h00, "eeprom ctl reset");
      rdc(`EPA_CTL_ADDR, 8'h00, "eprom ctl reset");
      chk("outputs reset", 32'h0, {27'h0, ee_pulse, ep_pulse, vconn});
   endtask

   task automatic t_ee_modes();
      wr(16'h1f60, 8'h5a);
      wr(`EE_CTL_ADDR, 8'h03);
      chk("eeprom pulse on", 32'h1, {31'h0, ee_pulse});
      rdc(16'h1f60, 8'h5a, "latched read");
      wr(16'h1f60, 8'ha5);
      rdc(16'h1f60, 8'h5a, "discarded write");
      wr(`EE_CTL_ADDR, 8'h01);
      rdc(`EE_CTL_ADDR, 8'h03, "select frozen");
      wr(`EE_CTL_ADDR, 8'h00);
      chk("eeprom pulse off", 32'h0, {31'h0, ee_pulse});
      rdc(`EE_CTL_ADDR, 8'h02, "select kept");
      rdc(16'h1f60, 8'h5a, "ones result");
      wr(16'h1f60, 8'h0f);
      wr(`EE_CTL_ADDR, 8'h01);
      wr(`EE_CTL_ADDR, 8'h00);
      rdc(16'h1f60, 8'h0a, "zeros result");
      rdc(`EE_CTL_ADDR, 8'h00, "zeros select");
   endtask

   // Block 3 protected through the first array byte
   task automatic t_protect();
      ee_prog(16'h1f00, 8'h08);
      rdc(16'h1f00, 8'h08, "protect byte");
      ee_prog(16'h1f60, 8'hf0);
      rdc(16'h1f60, 8'h0a, "protected block");
      ee_prog(16'h1f20, 8'h01);
      rdc(16'h1f20, 8'h01, "open block");
      override <= 1'h1;
      ee_prog(16'h1f60, 8'hf0);
      rdc(16'h1f60, 8'hfa, "override write");
      override <= 1'h0;
      wr(`EE_CTL_ADDR, 8'hfc);
      rdc(`EE_CTL_ADDR, 8'h00, "eeprom ctl unused");
   endtask

   task automatic t_eprom();
      wr(`EPA_CTL_ADDR, 8'hfe);
      rdc(`EPA_CTL_ADDR, 8'h40, "eprom ctl unused");
      chk("voltage connect", 32'h1, {30'h0, vconn});
      ep_prog(8'h5a);
      rdc(16'h6000, 8'hff, "no pin voltage");
      vpp_pin <= 1'h1;
      ep_prog(8'h5a);
      rdc(16'h6000, 8'h5a, "eprom programmed");
      ep_prog(8'ha5);
      rdc(16'h6000, 8'h00, "zeros only");
      wr(`EPA_CTL_ADDR, 8'h00);
      vpp_pin <= 1'h0;
      chk("voltage released", 32'h0, {30'h0, vconn});
      rdc(16'h7fff, 8'hff, "eprom top byte");
      rdc(`EPB_CTL_ADDR, 8'h00, "second ctl absent");
      rdc(16'h0000, 8'h00, "unmapped read");
   endtask

   task automatic t_apb_map();
      logic [31:0] r;
      logic e;
      apb(1'h0, 8'h10, 32'h0, r, e);
      chk("unmapped slverr", 32'h1, {31'h0, e});
      apb(1'h0, `H_STAT, 32'h0, r, e);
      chk("mapped slverr", 32'h0, {31'h0, e});
      // Enable low freezes the staging register at the last order, 0000
      ce <= 1'h0;
      apb(1'h1, `H_ADDR, 32'h0000_1234, r, e);
      ce <= 1'h1;
      apb(1'h0, `H_ADDR, 32'h0, r, e);
      chk("frozen address", 32'h0, r);
      apb(1'h1, `H_ADDR, 32'h0000_1234, r, e);
      apb(1'h0, `H_ADDR, 32'h0, r, e);
      chk("address written", 32'h0000_1234, r);
   endtask

   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'h1;
      t_reset();
      t_ee_modes();
      t_protect();
      t_eprom();
      t_apb_map();
      give_verdict();
   end
endmodule
